// File: sram_host_consts.svh
// timing constants for the async sram host controller
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define READ_CYCLE_NS 15
`define WRITE_CYCLE_NS 15
`define WRITE_PULSE_NS 10
`define WRITE_TO_RELEASE_TIME_NS 7
`define READ_ACCESS_NS 15
`define CEIL_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYC `CEIL_CYC(`WRITE_PULSE_NS)
`define WRITE_RECOV_CYC `CEIL_CYC(`WRITE_CYCLE_NS - `WRITE_PULSE_NS)
`define RELEASE_CYC `CEIL_CYC(`WRITE_TO_RELEASE_TIME_NS)
`define READ_CYC `CEIL_CYC(`READ_ACCESS_NS)
`define READ_RECOV_CYC 1
`endif

// File: sram_host_pkg.sv
// types for the async sram host controller
package sram_host_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_READ = 3'b001,
		ST_W_RELEASE = 3'b010,
		ST_W_PULSE = 3'b011,
		ST_W_RECOV = 3'b100,
		ST_R_RECOV = 3'b101
	} host_state_t;
endpackage : sram_host_pkg

// File: sram_pin_sync.sv
// two-flop synchroniser for the sram data pins
`timescale 1ns/10ps
`default_nettype none
module sram_pin_sync #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// pins
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	// first stage only feeds the second
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta <= '0;
			sync_o <= '0;
		end else begin
			meta <= pin_i;
			sync_o <= meta;
		end
	end
endmodule : sram_pin_sync
`default_nettype wire

// File: sram_host.sv
// host controller driving an async 16-bit sram through its strobes
// Overview of operation
// - write strobe stays high during reads
// - select read: address held, selects pulse low per access
// - address valid before chip select falls
// - address changes only with select or strobe high
// - no data drive while sram outputs
// - no opposing data during release window
// - output enable high to float pins
`include "sram_host_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module sram_host
	import sram_host_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 16,
	parameter int WRITE_PULSE_CYC = `WRITE_PULSE_CYC,
	parameter int WRITE_RECOV_CYC = `WRITE_RECOV_CYC,
	parameter int RELEASE_CYC = `RELEASE_CYC,
	parameter int READ_CYC = `READ_CYC
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// user request
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic [DATA_W-1:0] req_wdata_i,
	input wire logic [1:0] req_lane_i,
	output logic req_ready_o,
	output logic rd_valid_o,
	output logic [DATA_W-1:0] rd_data_o,
	// sram pins
	output logic [ADDR_W-1:0] sram_addr_o,
	output logic chip_sel_n_o,
	output logic out_en_n_o,
	output logic write_n_o,
	output logic low_byte_sel_n_o,
	output logic high_byte_sel_n_o,
	input wire logic [DATA_W-1:0] sram_data_i,
	output logic [DATA_W-1:0] sram_data_o,
	output logic sram_data_oe_n_o
);
	host_state_t state;
	logic [7:0] count;
	logic [1:0] lane;
	logic [DATA_W-1:0] data_sync;

	sram_pin_sync #(.WIDTH(DATA_W)) u_sync (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(sram_data_i),
		.sync_o(data_sync)
	);

	// state sequencing and cycle counts
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
			count <= 8'h00;
			lane <= 2'b00;
		end else begin
			case (state)
				ST_IDLE: begin
					if (req_i && req_lane_i != 2'b00) begin
						lane <= req_lane_i;
						// read waits access plus two sync stages
						count <= req_write_i ? 8'(RELEASE_CYC) : 8'(READ_CYC + 2);
						state <= req_write_i ? ST_W_RELEASE : ST_READ;
					end
				end
				ST_READ: begin
					if (count <= 8'h01) begin
						count <= 8'(`READ_RECOV_CYC);
						state <= ST_R_RECOV;
					end else begin
						count <= count - 8'h01;
					end
				end
				ST_R_RECOV: begin
					if (count <= 8'h01) begin
						state <= ST_IDLE;
					end else begin
						count <= count - 8'h01;
					end
				end
				ST_W_RELEASE: begin
					if (count <= 8'h01) begin
						count <= 8'(WRITE_PULSE_CYC);
						state <= ST_W_PULSE;
					end else begin
						count <= count - 8'h01;
					end
				end
				ST_W_PULSE: begin
					if (count <= 8'h01) begin
						count <= 8'(WRITE_RECOV_CYC);
						state <= ST_W_RECOV;
					end else begin
						count <= count - 8'h01;
					end
				end
				ST_W_RECOV: begin
					if (count <= 8'h01) begin
						state <= ST_IDLE;
					end else begin
						count <= count - 8'h01;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// address latched only in idle, when chip select is high
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sram_addr_o <= '0;
			sram_data_o <= '0;
		end else if (state == ST_IDLE && req_i) begin
			sram_addr_o <= req_addr_i;
			sram_data_o <= req_wdata_i;
		end
	end

	// strobes; chip select falls one cycle after address settles
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			chip_sel_n_o <= 1'b1;
			out_en_n_o <= 1'b1;
			write_n_o <= 1'b1;
			low_byte_sel_n_o <= 1'b1;
			high_byte_sel_n_o <= 1'b1;
			sram_data_oe_n_o <= 1'b1;
		end else begin
			chip_sel_n_o <= !(state == ST_READ || state == ST_W_RELEASE || state == ST_W_PULSE);
			// enable off for writes so outputs release
			out_en_n_o <= !(state == ST_READ);
			// strobe only low in pulse state, never in reads
			write_n_o <= !(state == ST_W_PULSE && count > 8'h01);
			low_byte_sel_n_o <= !((state == ST_READ || state == ST_W_RELEASE
				|| state == ST_W_PULSE) && lane[0]);
			high_byte_sel_n_o <= !((state == ST_READ || state == ST_W_RELEASE
				|| state == ST_W_PULSE) && lane[1]);
			// drive only after the release wait, released WRITE_RECOV_CYC cycles after strobe rises
			sram_data_oe_n_o <= !(state == ST_W_PULSE || state == ST_W_RECOV && count > 8'h01);
		end
	end

	// read data capture and handshake
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o <= '0;
			req_ready_o <= 1'b0;
		end else begin
			rd_valid_o <= (state == ST_READ && count <= 8'h01);
			if (state == ST_READ && count <= 8'h01) begin
				rd_data_o <= data_sync;
			end
			req_ready_o <= (state == ST_IDLE && !req_i);
		end
	end
endmodule : sram_host
`default_nettype wire

// File: sram_host_sva.sv
// pin-level assertions for the sram host controller
`timescale 1ns/10ps
`default_nettype none
module sram_host_sva #(parameter int WRITE_PULSE_CYC = 2) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// sram pins
	input wire logic [17:0] sram_addr_o,
	input wire logic chip_sel_n_o,
	input wire logic out_en_n_o,
	input wire logic write_n_o,
	input wire logic low_byte_sel_n_o,
	input wire logic high_byte_sel_n_o,
	input wire logic sram_data_oe_n_o
);
	int low_cnt;
	// counter, since the pulse length is a parameter
	always_ff @(posedge clock_i or posedge sys_rst_i)
		if (sys_rst_i) low_cnt <= 0;
		else low_cnt <= write_n_o ? 0 : low_cnt + 1;
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	read_strobe_a: assert property (!chip_sel_n_o && !out_en_n_o |-> write_n_o)
		else $error("strobe low in read");
	read_lane_a: assert property (!chip_sel_n_o && !out_en_n_o |-> !(low_byte_sel_n_o && high_byte_sel_n_o))
		else $error("read with no lane");
	sel_addr_a: assert property ($fell(chip_sel_n_o) |-> $stable(sram_addr_o))
		else $error("address moved at select");
	addr_change_a: assert property ($changed(sram_addr_o) |-> write_n_o && $past(write_n_o))
		else $error("address moved in write");
	write_data_a: assert property (!write_n_o |-> !chip_sel_n_o && !sram_data_oe_n_o)
		else $error("strobe without data");
	drive_excl_a: assert property (!sram_data_oe_n_o |-> out_en_n_o)
		else $error("bus contention");
	release_gap_a: assert property (!sram_data_oe_n_o |-> $past(out_en_n_o))
		else $error("drove before release");
	end_release_a: assert property ($rose(write_n_o) && !chip_sel_n_o |-> out_en_n_o)
		else $error("output on after write");
	pulse_width_a: assert property ($rose(write_n_o) |-> low_cnt == WRITE_PULSE_CYC - 1)
		else $error("write pulse length");
	cover property ($rose(write_n_o));
	cover property ($fell(out_en_n_o));
	cover property (!chip_sel_n_o && (low_byte_sel_n_o ^ high_byte_sel_n_o));
endmodule : sram_host_sva
bind sram_host sram_host_sva #(.WRITE_PULSE_CYC(WRITE_PULSE_CYC)) i_sva (.*);
`default_nettype wire

// File: sram_model.sv
// behavioural async sram on the far side of the host
`timescale 1ns/10ps
`default_nettype none
module sram_model (
	input wire logic [17:0] a_i,
	input wire logic cs_n_i, oe_n_i, we_n_i, lb_n_i, ub_n_i,
	input wire logic [15:0] d_i,
	output logic [15:0] d_o
);
	logic [15:0] mem [256];
	logic t = 0;
	wire logic rd = !cs_n_i && !oe_n_i && we_n_i;
	always #5 t = ~t;
	always @* begin
		if (!cs_n_i && !we_n_i) begin
			if (!lb_n_i) mem[a_i[7:0]][7:0] = d_i[7:0];
			if (!ub_n_i) mem[a_i[7:0]][15:8] = d_i[15:8];
		end
	end
	// floated lanes toggle so stale data never passes
	assign d_o[7:0] = rd && !lb_n_i ? mem[a_i[7:0]][7:0] : {8{t}};
	assign d_o[15:8] = rd && !ub_n_i ? mem[a_i[7:0]][15:8] : {8{~t}};
endmodule : sram_model
`default_nettype wire

// File: tb.sv
// self-checking testbench for the sram host controller
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clock_i = 0, sys_rst_i = 1, req_i = 0, req_write_i = 0;
	logic [17:0] req_addr_i = 0;
	logic [15:0] req_wdata_i = 0;
	logic [1:0] req_lane_i = 0;
	logic req_ready_o, rd_valid_o, chip_sel_n_o, out_en_n_o, write_n_o;
	logic low_byte_sel_n_o, high_byte_sel_n_o, sram_data_oe_n_o;
	logic [15:0] rd_data_o, sram_data_o, m_o, ref_mem [16];
	logic [17:0] sram_addr_o;
	wire logic [15:0] sram_data_i = sram_data_oe_n_o ? m_o : sram_data_o;
	int errors = 0, n_checks = 0, seed = 83;
	initial forever #5 clock_i = ~clock_i;
	sram_host #(.WRITE_PULSE_CYC(3)) i_dut (.*);
	sram_model i_mem (.a_i(sram_addr_o), .cs_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o),
		.we_n_i(write_n_o), .lb_n_i(low_byte_sel_n_o), .ub_n_i(high_byte_sel_n_o),
		.d_i(sram_data_i), .d_o(m_o));
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_sim
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tmo(int i);
		if (i == 50) begin
			errors++;
			end_sim();
		end
	endtask : tmo
	task automatic op(logic w, logic [3:0] ad, logic [1:0] ln, logic [15:0] wd);
		int i;
		logic [15:0] m;
		for (i = 0; i < 50 && req_ready_o !== 1'b1; i++) @(negedge clock_i);
		tmo(i);
		req_i = 1;
		req_write_i = w;
		req_addr_i = {14'h0, ad};
		req_lane_i = ln;
		req_wdata_i = wd;
		@(negedge clock_i);
		req_i = 0;
		m = {{8{ln[1]}}, {8{ln[0]}}};
		// a zero lane mask is ignored, so the reference stays put
		if (w) ref_mem[ad] = ref_mem[ad] & ~m | wd & m;
		else if (ln != 0) begin
			for (i = 0; i < 50 && rd_valid_o !== 1'b1; i++) @(negedge clock_i);
			tmo(i);
			chk("rd_data", rd_data_o & m, ref_mem[ad] & m);
		end
		repeat (2) @(negedge clock_i);
	endtask : op
	initial begin
		int k;
		repeat (16) @(negedge clock_i);
		chk("reset pins", {11'h0, chip_sel_n_o, out_en_n_o, write_n_o,
			low_byte_sel_n_o, high_byte_sel_n_o}, 16'h001f);
		sys_rst_i = 0;
		for (k = 0; k < 16; k++) op(1, k, 3, $random(seed));
		for (k = 0; k < 80; k++) op($random(seed), $random(seed), $random(seed), $random(seed));
		end_sim();
	end
endmodule : tb
`default_nettype wire
